// [inc/dtm_pkg.sv]
// constants and types shared by the dual timer mode control block
package dtm_pkg;
  localparam logic [7:0] DTM_MODE_SEL_ADDR = 8'h89;
  localparam logic [7:0] DTM_MODE_SEL_RST = 8'h00;
  localparam int DTM_T1_GATE_BIT = 7;
  localparam int DTM_T1_SRC_BIT = 6;
  localparam int DTM_T1_MODE_HI = 5;
  localparam int DTM_T1_MODE_LO = 4;
  localparam int DTM_T0_GATE_BIT = 3;
  localparam int DTM_T0_SRC_BIT = 2;
  localparam int DTM_T0_MODE_HI = 1;
  localparam int DTM_T0_MODE_LO = 0;
  localparam int DTM_PRESC_DIV = 12;
  localparam logic [7:0] DTM_BYTE_ZERO = 8'h00;
  localparam logic [7:0] DTM_BYTE_ONE = 8'h01;
  localparam logic [7:0] DTM_BYTE_FULL = 8'hFF;
  localparam logic [12:0] DTM_MODE0_FULL = 13'h1FFF;
  localparam logic [12:0] DTM_MODE0_ONE = 13'h0001;
  localparam logic [15:0] DTM_MODE1_FULL = 16'hFFFF;
  localparam logic [15:0] DTM_MODE1_ONE = 16'h0001;

  typedef enum logic [1:0] {
    DTM_MODE_13BIT = 2'h0,
    DTM_MODE_16BIT = 2'h1,
    DTM_MODE_RELOAD = 2'h2,
    DTM_MODE_SPLIT = 2'h3
  } dtm_mode_t;
endpackage

// [src/dtm_tick_sel.sv]
// per-timer count enable: gating, source select and falling-edge detect
`timescale 1ns/100ps
module dtm_tick_sel
  import dtm_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_run,
  input wire logic i_gate_enable,
  input wire logic i_irq_pin,
  input wire logic i_irq_polarity,
  input wire logic i_count_source,
  input wire logic i_presc_select,
  input wire logic i_presc_tick,
  input wire logic i_count_pin,
  // result
  output logic o_tick
);
  logic pin_q;
  logic pin_qq;
  logic fall;
  logic enabled;
  logic internal;

  // pin sampled twice, falling edge seen between the two samples
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_q <= 1'b0;
      pin_qq <= 1'b0;
    end else begin
      pin_q <= i_count_pin;
      pin_qq <= pin_q;
    end
  end

  assign fall = pin_qq & ~pin_q;
  assign enabled = i_run & (~i_gate_enable |
                   (i_irq_pin == i_irq_polarity));
  assign internal = i_presc_select | i_presc_tick;
  assign o_tick = enabled & (i_count_source ? fall : internal);

  chk_gate_blocks: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_gate_enable && (i_irq_pin != i_irq_polarity)) || !i_run |-> !o_tick)
    else $error("tick while gated off");

  sequence s_pin_fall;
    pin_q ##1 !pin_q;
  endsequence

  chk_edge_counts: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    s_pin_fall ##0 (i_run && i_count_source && !i_gate_enable) |-> o_tick)
    else $error("falling edge missed");

  chk_level_quiet: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_count_source && $stable(pin_q) && pin_q == pin_qq |-> !o_tick)
    else $error("count on steady level");

  chk_internal_src: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_run && !i_gate_enable && !i_count_source && i_presc_select
    |-> o_tick)
    else $error("internal clock tick missing");
endmodule // dtm_tick_sel

// [src/dtm_timers.sv]
// dual timer with mode register, gating, source select and mode counters
`timescale 1ns/100ps
module dtm_timers
  import dtm_pkg::*;
#(
  parameter int PRESC_DIV = DTM_PRESC_DIV
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // run bits and clock control prescale selects
  input wire logic i_timer_zero_run,
  input wire logic i_timer_one_run,
  input wire logic i_timer_zero_presc_sel,
  input wire logic i_timer_one_presc_sel,
  // external interrupt pins and polarity from pin config
  input wire logic i_ext_irq_zero_pin,
  input wire logic i_ext_irq_one_pin,
  input wire logic i_ext_irq_zero_polarity,
  input wire logic i_ext_irq_one_polarity,
  // external count pins
  input wire logic i_timer_zero_count_pin,
  input wire logic i_timer_one_count_pin,
  // counter state and overflow pulses
  output logic [15:0] o_timer_zero_count,
  output logic [15:0] o_timer_one_count,
  output logic o_timer_zero_ovf,
  output logic o_timer_one_ovf
);
  localparam int PW = $clog2(PRESC_DIV + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1);
  localparam logic [PW-1:0] PRESC_ONE = PW'(1);

  logic [7:0] timer_mode_select;
  logic [PW-1:0] presc_cnt;
  logic presc_tick;
  logic tick0;
  logic tick1;
  logic th0_tick;
  dtm_mode_t mode0;
  dtm_mode_t mode1;
  logic [16:0] next_t0;
  logic [16:0] next_t1;
  logic [8:0] next_th0_split;

  assign mode0 = dtm_mode_t'(timer_mode_select[DTM_T0_MODE_HI:
                                               DTM_T0_MODE_LO]);
  assign mode1 = dtm_mode_t'(timer_mode_select[DTM_T1_MODE_HI:
                                               DTM_T1_MODE_LO]);

  // mode select register write and read back
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer_mode_select <= DTM_MODE_SEL_RST;
    end else if (i_sfr_wr && i_sfr_addr == DTM_MODE_SEL_ADDR) begin
      timer_mode_select <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= DTM_BYTE_ZERO;
    end else if (i_sfr_addr == DTM_MODE_SEL_ADDR) begin
      o_sfr_rdata <= timer_mode_select;
    end else begin
      o_sfr_rdata <= DTM_BYTE_ZERO;
    end
  end

  // system clock prescaler
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      presc_cnt <= '0;
    end else if (presc_cnt == PRESC_LAST) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= presc_cnt + PRESC_ONE;
    end
  end
  assign presc_tick = (presc_cnt == PRESC_LAST);

  dtm_tick_sel u_sel_zero (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_run(i_timer_zero_run),
    .i_gate_enable(timer_mode_select[DTM_T0_GATE_BIT]),
    .i_irq_pin(i_ext_irq_zero_pin),
    .i_irq_polarity(i_ext_irq_zero_polarity),
    .i_count_source(timer_mode_select[DTM_T0_SRC_BIT]),
    .i_presc_select(i_timer_zero_presc_sel),
    .i_presc_tick(presc_tick),
    .i_count_pin(i_timer_zero_count_pin),
    .o_tick(tick0)
  );

  dtm_tick_sel u_sel_one (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_run(i_timer_one_run),
    .i_gate_enable(timer_mode_select[DTM_T1_GATE_BIT]),
    .i_irq_pin(i_ext_irq_one_pin),
    .i_irq_polarity(i_ext_irq_one_polarity),
    .i_count_source(timer_mode_select[DTM_T1_SRC_BIT]),
    .i_presc_select(i_timer_one_presc_sel),
    .i_presc_tick(presc_tick),
    .i_count_pin(i_timer_one_count_pin),
    .o_tick(tick1)
  );

  // one counting step; bit 16 of the result is the overflow
  function automatic logic [16:0] step(input dtm_mode_t mode,
                                       input logic [15:0] cnt);
    logic [12:0] c13;
    logic [16:0] res;
    c13 = {cnt[15:8], cnt[4:0]};
    res = {1'b0, cnt};
    unique case (mode)
      DTM_MODE_13BIT: begin
        c13 = c13 + DTM_MODE0_ONE;
        res = {({cnt[15:8], cnt[4:0]} == DTM_MODE0_FULL),
               c13[12:5], cnt[7:5], c13[4:0]};
      end
      DTM_MODE_16BIT: begin
        res = {(cnt == DTM_MODE1_FULL), cnt + DTM_MODE1_ONE};
      end
      DTM_MODE_RELOAD: begin
        if (cnt[7:0] == DTM_BYTE_FULL) begin
          res = {1'b1, cnt[15:8], cnt[15:8]};
        end else begin
          res = {1'b0, cnt[15:8], cnt[7:0] + DTM_BYTE_ONE};
        end
      end
      DTM_MODE_SPLIT: begin
        res = {(cnt[7:0] == DTM_BYTE_FULL), cnt[15:8],
               cnt[7:0] + DTM_BYTE_ONE};
      end
    endcase
    return res;
  endfunction

  assign next_t0 = step(mode0, o_timer_zero_count);
  assign next_t1 = step(mode1, o_timer_one_count);
  assign next_th0_split = {1'b0, o_timer_zero_count[15:8]} + 9'h001;
  // split high byte runs on the internal clock under timer one run
  assign th0_tick = i_timer_one_run &
                    (i_timer_zero_presc_sel | presc_tick);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_timer_zero_count <= {DTM_BYTE_ZERO, DTM_BYTE_ZERO};
    end else if (mode0 == DTM_MODE_SPLIT) begin
      if (tick0) begin
        o_timer_zero_count[7:0] <= next_t0[7:0];
      end
      if (th0_tick) begin
        o_timer_zero_count[15:8] <= next_th0_split[7:0];
      end
    end else if (tick0) begin
      o_timer_zero_count <= next_t0[15:0];
    end
  end

  // timer one holds in mode three
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_timer_one_count <= {DTM_BYTE_ZERO, DTM_BYTE_ZERO};
    end else if (tick1 && mode1 != DTM_MODE_SPLIT) begin
      o_timer_one_count <= next_t1[15:0];
    end
  end

  // overflow pulses; split high byte overflow takes timer one's flag
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_timer_zero_ovf <= 1'b0;
      o_timer_one_ovf <= 1'b0;
    end else begin
      o_timer_zero_ovf <= tick0 & next_t0[16];
      if (mode0 == DTM_MODE_SPLIT) begin
        o_timer_one_ovf <= th0_tick & next_th0_split[8];
      end else begin
        o_timer_one_ovf <= tick1 & (mode1 != DTM_MODE_SPLIT) &
                           next_t1[16];
      end
    end
  end

  chk_mode_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_sfr_wr && i_sfr_addr == DTM_MODE_SEL_ADDR
    ##1 (i_sfr_addr == DTM_MODE_SEL_ADDR)
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
    else $error("mode register read back wrong");

  chk_t1_inactive: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode1 == DTM_MODE_SPLIT |=> $stable(o_timer_one_count))
    else $error("timer one moved while inactive");

  chk_t1_sixteen: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick1 && mode1 == DTM_MODE_16BIT
    |=> o_timer_one_count == $past(o_timer_one_count) + DTM_MODE1_ONE)
    else $error("16-bit increment wrong");

  chk_t0_reload: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick0 && mode0 == DTM_MODE_RELOAD
    && o_timer_zero_count[7:0] == DTM_BYTE_FULL
    |=> o_timer_zero_count[7:0] == $past(o_timer_zero_count[15:8])
    && o_timer_zero_ovf)
    else $error("auto reload wrong");

  chk_t0_thirteen: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick0 && mode0 == DTM_MODE_13BIT
    && o_timer_zero_count[4:0] != 5'h1F
    |=> o_timer_zero_count[15:8] == $past(o_timer_zero_count[15:8]))
    else $error("13-bit high byte moved early");
endmodule // dtm_timers

// [testbench/dtm_pin_model.sv]
// external count pin model: bursts of falling edges on request
`timescale 1ns/100ps
module dtm_pin_model (
  // clock and request
  input wire logic i_ref_clk,
  input wire logic i_start,
  input wire logic [7:0] i_pulses,
  input wire logic [7:0] i_width,
  // pin and status
  output logic o_count_pin,
  output logic o_busy
);
  // each level is held for i_width whole cycles so it is always sampled
  initial begin
    o_count_pin = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_ref_clk);
      if (i_start === 1'b1) begin
        o_busy = 1'b1;
        for (int k = 0; k < i_pulses; k++) begin
          @(negedge i_ref_clk);
          o_count_pin = 1'b0;
          repeat (i_width) @(negedge i_ref_clk);
          o_count_pin = 1'b1;
          repeat (i_width - 1) @(negedge i_ref_clk);
        end
        o_busy = 1'b0;
      end
    end
  end
endmodule // dtm_pin_model

// [testbench/tb_top.sv]
// self-checking bench for the dual timer mode control block
`timescale 1ns/100ps
module tb_top;
  import dtm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic run0 = 1'b0, run1 = 1'b0, ps0 = 1'b1, ps1 = 1'b1;
  logic irq0 = 1'b0, irq1 = 1'b0, pol0 = 1'b1, pol1 = 1'b1;
  logic go = 1'b0, pin0, pin1, busy0, busy1, ovf0, ovf1;
  logic [7:0] np0 = 8'h06, np1 = 8'h09;
  logic [15:0] cnt0, cnt1;
  int error_cnt = 0, n_compared = 0, ovf0_n = 0, ovf1_n = 0;

  initial begin
    forever #10 clk = ~clk;
  end

  dtm_timers #(.PRESC_DIV(2)) dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_timer_zero_run(run0), .i_timer_one_run(run1),
    .i_timer_zero_presc_sel(ps0), .i_timer_one_presc_sel(ps1),
    .i_ext_irq_zero_pin(irq0), .i_ext_irq_one_pin(irq1),
    .i_ext_irq_zero_polarity(pol0), .i_ext_irq_one_polarity(pol1),
    .i_timer_zero_count_pin(pin0), .i_timer_one_count_pin(pin1),
    .o_timer_zero_count(cnt0), .o_timer_one_count(cnt1),
    .o_timer_zero_ovf(ovf0), .o_timer_one_ovf(ovf1));
  dtm_pin_model pm0 (.i_ref_clk(clk), .i_start(go), .i_pulses(np0),
    .i_width(8'h02), .o_count_pin(pin0), .o_busy(busy0));
  dtm_pin_model pm1 (.i_ref_clk(clk), .i_start(go), .i_pulses(np1),
    .i_width(8'h03), .o_count_pin(pin1), .o_busy(busy1));

  always @(negedge clk) begin
    if (ovf0 === 1'b1) ovf0_n++;
    if (ovf1 === 1'b1) ovf1_n++;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    ovf0_n = 0;
    ovf1_n = 0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  task automatic run(input int n, input logic r0, input logic r1);
    @(negedge clk);
    run0 = r0;
    run1 = r1;
    repeat (n) @(negedge clk);
    run0 = 1'b0;
    run1 = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic counts(input logic [15:0] e0, input logic [15:0] e1);
    chk(cnt0, e0);
    chk(cnt1, e1);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd_reg(DTM_MODE_SEL_ADDR, DTM_MODE_SEL_RST);
    wr_reg(DTM_MODE_SEL_ADDR, 8'ha5);
    rd_reg(DTM_MODE_SEL_ADDR, 8'ha5);
    rd_reg(8'h8a, 8'h00);
    do_reset();
    rd_reg(DTM_MODE_SEL_ADDR, DTM_MODE_SEL_RST);
    $display("test register done");
    wr_reg(DTM_MODE_SEL_ADDR, 8'h11);
    run(300, 1'b1, 1'b1);
    counts(16'h012c, 16'h012c);
    chk(16'(ovf0_n + ovf1_n), 16'h0000);
    do_reset();
    run(40, 1'b1, 1'b1);
    counts(16'h0108, 16'h0108);
    do_reset();
    wr_reg(DTM_MODE_SEL_ADDR, 8'h22);
    run(256, 1'b1, 1'b1);
    counts(16'h0000, 16'h0000);
    chk(16'(ovf0_n * 2 + ovf1_n), 16'h0003);
    do_reset();
    wr_reg(DTM_MODE_SEL_ADDR, 8'h33);
    run(5, 1'b1, 1'b0);
    counts(16'h0005, 16'h0000);
    run(7, 1'b0, 1'b1);
    counts(16'h0705, 16'h0000);
    run(249, 1'b0, 1'b1);
    counts(16'h0005, 16'h0000);
    chk(16'(ovf1_n), 16'h0001);
    $display("test modes done");
    do_reset();
    wr_reg(DTM_MODE_SEL_ADDR, 8'h88);
    run(10, 1'b1, 1'b1);
    counts(16'h0000, 16'h0000);
    irq0 = 1'b1;
    irq1 = 1'b1;
    run(10, 1'b1, 1'b1);
    counts(16'h000a, 16'h000a);
    pol0 = 1'b0;
    pol1 = 1'b0;
    run(6, 1'b1, 1'b1);
    counts(16'h000a, 16'h000a);
    irq0 = 1'b0;
    irq1 = 1'b0;
    run(6, 1'b1, 1'b1);
    counts(16'h0010, 16'h0010);
    $display("test gate done");
    do_reset();
    wr_reg(DTM_MODE_SEL_ADDR, 8'h11);
    ps0 = 1'b0;
    ps1 = 1'b0;
    run(20, 1'b1, 1'b1);
    counts(16'h000a, 16'h000a);
    ps0 = 1'b1;
    ps1 = 1'b1;
    do_reset();
    wr_reg(DTM_MODE_SEL_ADDR, 8'h55);
    @(negedge clk);
    run0 = 1'b1;
    run1 = 1'b1;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 400 && (busy0 !== 1'b0 || busy1 !== 1'b0); i++) begin
      @(negedge clk);
    end
    chk({14'h0000, busy1, busy0}, 16'h0000);
    if (busy0 === 1'b0 && busy1 === 1'b0) begin
      repeat (4) @(negedge clk);
      counts(16'h0006, 16'h0009);
      repeat (20) @(negedge clk);
      counts(16'h0006, 16'h0009);
    end
    run0 = 1'b0;
    run1 = 1'b0;
    $display("test external done");
    complete_run();
  end
endmodule // tb_top
